// ### src/apwp_params.svh
`ifndef APWP_PARAMS_SVH
`define APWP_PARAMS_SVH

`define APWP_WORD_W        16
`define APWP_BYTE_W        8
`define APWP_SHARED_BIT    8
`define APWP_RESTORE_WORD  16'h0002
`define APWP_FIFO_DEPTH    32
`define APWP_WORD_RESET    16'h0000
`define APWP_BYTE_RESET    8'h00

`endif

// ### src/apwp_pkg.sv
`include "apwp_params.svh"

package apwp_pkg;

	typedef enum logic {
		APWP_BYTE_MODE,
		APWP_WORD_MODE
	} apwp_mode_t;

	typedef enum logic [0:0] {
		APWP_STAGE_EMPTY,
		APWP_STAGE_LOW_HELD
	} apwp_stage_t;

	typedef struct packed {
		logic                     restore;
		logic [`APWP_WORD_W-1:0] word;
	} apwp_wr_t;

endpackage

// ### src/apwp_port.sv
`include "apwp_params.svh"

module apwp_fifo #(
	parameter int W     = 17,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   count_q;
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;

	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module apwp_port
	import apwp_pkg::*;
#(
	parameter int DEPTH = `APWP_FIFO_DEPTH
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    chip_select_n,
	input  wire logic                    write_n,
	input  wire logic                    read_n,
	input  wire logic                    width_select,
	input  wire logic [`APWP_WORD_W-1:0] data_in,
	output logic      [`APWP_WORD_W-1:0] data_out,
	output logic                         data_oe,
	output logic                         port_wait,
	input  wire logic [`APWP_WORD_W-1:0] read_word,
	output logic                         cal_pointer_advance,
	output logic                         word_valid,
	input  wire logic                    word_ready,
	output logic      [`APWP_WORD_W-1:0] word_data,
	output logic                         test_restore
);
	localparam int SW = 4;

	logic [SW-1:0]           ctl_s1_q;
	logic [SW-1:0]           ctl_s2_q;
	logic [SW-1:0]           ctl_s3_q;
	logic [`APWP_WORD_W-1:0] din_s1_q;
	logic [`APWP_WORD_W-1:0] din_s2_q;
	logic [`APWP_WORD_W-1:0] din_s3_q;
	logic [`APWP_BYTE_W-1:0] low_byte_q;
	apwp_stage_t             stage_q;
	apwp_stage_t             stage_d;
	logic                    data_oe_q;
	logic [`APWP_WORD_W-1:0] data_out_q;
	logic                    cal_adv_q;
	logic                    wait_q;
	logic                    word_valid_q;
	logic [`APWP_WORD_W-1:0] word_data_q;
	logic                    restore_q;

	wire               cs_now   = !ctl_s2_q[0];
	wire               wr_now   = !ctl_s2_q[1];
	wire               rd_now   = !ctl_s2_q[2];
	wire               cs_was   = !ctl_s3_q[0];
	wire               wr_was   = !ctl_s3_q[1];
	wire               rd_was   = !ctl_s3_q[2];
	apwp_mode_t        mode;
	wire               high_byte_enable     = din_s3_q[`APWP_SHARED_BIT];
	wire               wr_rise  = wr_was && !wr_now && cs_was;
	wire               rd_rise  = rd_was && !rd_now && cs_was;
	wire               rd_drive = cs_now && rd_now;
	wire               byte_hi  = (mode == APWP_BYTE_MODE) && high_byte_enable;
	wire [`APWP_WORD_W-1:0] word_full = din_s3_q;
	wire [`APWP_WORD_W-1:0] word_pair = {din_s3_q[`APWP_BYTE_W-1:0], low_byte_q};
	wire [`APWP_WORD_W-1:0] word_new  = (mode == APWP_WORD_MODE) ? word_full : word_pair;
	wire               commit   = wr_rise && ((mode == APWP_WORD_MODE) || high_byte_enable);
	wire               is_rest  = (word_new == `APWP_RESTORE_WORD);
	apwp_wr_t          fifo_in;
	apwp_wr_t          fifo_out;
	wire               fifo_in_ready;
	wire               fifo_out_valid;
	wire               take_out = fifo_out_valid && (!word_valid_q || word_ready);
	// Read selection uses the same stage as the output enable, so the first driven cycle is right.
	wire               rd_word  = ctl_s2_q[3];
	wire               rd_hi    = !rd_word && din_s2_q[`APWP_SHARED_BIT];
	wire [`APWP_WORD_W-1:0] rd_byte_sel =
		rd_hi ? {{`APWP_BYTE_W{1'b0}}, read_word[`APWP_WORD_W-1:`APWP_BYTE_W]}
		      : {{`APWP_BYTE_W{1'b0}}, read_word[`APWP_BYTE_W-1:0]};
	wire [`APWP_WORD_W-1:0] rd_value = rd_word ? read_word : rd_byte_sel;

	assign mode    = ctl_s3_q[3] ? APWP_WORD_MODE : APWP_BYTE_MODE;
	assign fifo_in = '{restore: is_rest, word: word_new};

	always_comb begin
		stage_d = stage_q;
		if (wr_rise && mode == APWP_BYTE_MODE) begin
			stage_d = high_byte_enable ? APWP_STAGE_EMPTY : APWP_STAGE_LOW_HELD;
		end
		if (mode == APWP_WORD_MODE) begin
			stage_d = APWP_STAGE_EMPTY;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_s1_q <= 4'hf;
			ctl_s2_q <= 4'hf;
			ctl_s3_q <= 4'hf;
			din_s1_q <= `APWP_WORD_RESET;
			din_s2_q <= `APWP_WORD_RESET;
			din_s3_q <= `APWP_WORD_RESET;
		end else begin
			ctl_s1_q <= {width_select, read_n, write_n, chip_select_n};
			ctl_s2_q <= ctl_s1_q;
			ctl_s3_q <= ctl_s2_q;
			din_s1_q <= data_in;
			din_s2_q <= din_s1_q;
			din_s3_q <= din_s2_q;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_q    <= APWP_STAGE_EMPTY;
			low_byte_q <= `APWP_BYTE_RESET;
		end else begin
			stage_q <= stage_d;
			if (wr_rise && mode == APWP_BYTE_MODE && !high_byte_enable) begin
				low_byte_q <= din_s3_q[`APWP_BYTE_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_oe_q  <= 1'b0;
			data_out_q <= `APWP_WORD_RESET;
			cal_adv_q  <= 1'b0;
		end else begin
			data_oe_q  <= rd_drive;
			data_out_q <= rd_value;
			cal_adv_q  <= rd_rise && byte_hi;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_q       <= 1'b0;
			word_valid_q <= 1'b0;
			word_data_q  <= `APWP_WORD_RESET;
			restore_q    <= 1'b0;
		end else begin
			wait_q    <= !fifo_in_ready;
			restore_q <= take_out && fifo_out.restore;
			if (take_out) begin
				word_valid_q <= 1'b1;
				word_data_q  <= fifo_out.word;
			end else if (word_ready) begin
				word_valid_q <= 1'b0;
			end
		end
	end

	apwp_fifo #(
		.W     ($bits(apwp_wr_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (commit),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (take_out),
		.out_data  (fifo_out)
	);

	assign data_out            = data_out_q;
	assign data_oe             = data_oe_q;
	assign port_wait           = wait_q;
	assign cal_pointer_advance = cal_adv_q;
	assign word_valid          = word_valid_q;
	assign word_data           = word_data_q;
	assign test_restore        = restore_q;
endmodule

// ### verification/apwp_host.sv
module apwp_host (
	input wire logic        clk,
	input wire logic [15:0] data_out,
	output logic            chip_select_n,
	output logic            write_n,
	output logic            read_n,
	output logic            width_select,
	output logic [15:0]     data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{chip_select_n, write_n, read_n, width_select} = 4'hf;
		data_in = 16'h0000;
	end
	task automatic strobe(input logic [15:0] d);
		@(posedge clk);
		chip_select_n <= 1'b0;
		write_n <= 1'b0;
		data_in <= d;
		repeat (4) @(posedge clk);
		chip_select_n <= 1'b1;
		write_n <= 1'b1;
		repeat (4) @(posedge clk);
		data_in <= ~d;
	endtask
	task automatic wr(input logic m, input logic [15:0] d);
		width_select <= m;
		if (m) begin
			strobe(d);
		end else begin
			strobe({8'h00, d[7:0]});
			strobe({7'h00, 1'b1, d[15:8]});
		end
	endtask
	task automatic rd(input logic m, input logic h, output logic [15:0] q);
		width_select <= m;
		@(posedge clk);
		chip_select_n <= 1'b0;
		read_n <= 1'b0;
		data_in <= {7'h00, h, 8'h00};
		repeat (5) @(posedge clk);
		q = data_out;
		chip_select_n <= 1'b1;
		read_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
endmodule

// ### verification/apwp_port_asserts.sv
`include "apwp_params.svh"
module apwp_port_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        chip_select_n,
	input wire logic        write_n,
	input wire logic        read_n,
	input wire logic        width_select,
	input wire logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic        data_oe,
	input wire logic        port_wait,
	input wire logic [15:0] read_word,
	input wire logic        cal_pointer_advance,
	input wire logic        word_valid,
	input wire logic        word_ready,
	input wire logic [15:0] word_data,
	input wire logic        test_restore
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	property p_oe_cause;
		data_oe |-> $past(!chip_select_n && !read_n, 3);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe without select");
	property p_oe_off;
		$rose(read_n) |-> ##[1:4] !data_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus not released");
	property p_rdata;
		data_oe |-> data_out == (width_select ? read_word :
			{8'h00, data_in[8] ? read_word[15:8] : read_word[7:0]});
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data wrong");
	property p_wr_word;
		$rose(write_n) && !$past(chip_select_n) && width_select && !port_wait && word_ready
			|-> ##[3:8] word_valid;
	endproperty
	a_wr_word: assert property (p_wr_word) else $error("word not taken");
	property p_restore;
		test_restore |-> (word_valid && word_data == `APWP_RESTORE_WORD) ##1 !test_restore;
	endproperty
	a_restore: assert property (p_restore) else $error("restore wrong");
	property p_cal;
		cal_pointer_advance |-> !width_select && !data_oe && $past(data_oe);
	endproperty
	a_cal: assert property (p_cal) else $error("pointer pulse wrong");
	property p_low_hold;
		$rose(write_n) && !$past(chip_select_n) && !width_select && !data_in[8] && !word_valid
			|-> ##1 !word_valid [*6];
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low byte leaked");
	property p_hold;
		word_valid && !word_ready |=> word_valid && $stable(word_data);
	endproperty
	a_hold: assert property (p_hold) else $error("word not held");
endmodule
bind apwp_port apwp_port_chk u_chk (
	.clk                 (clk),
	.reset_n             (reset_n),
	.chip_select_n       (chip_select_n),
	.write_n             (write_n),
	.read_n              (read_n),
	.width_select        (width_select),
	.data_in             (data_in),
	.data_out            (data_out),
	.data_oe             (data_oe),
	.port_wait           (port_wait),
	.read_word           (read_word),
	.cal_pointer_advance (cal_pointer_advance),
	.word_valid          (word_valid),
	.word_ready          (word_ready),
	.word_data           (word_data),
	.test_restore        (test_restore)
);

// ### verification/tb_adc_parallel_write_port.sv
`include "apwp_params.svh"
module tb_adc_parallel_write_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 4;
	logic        clk, reset_n, word_ready, chip_select_n, write_n, read_n, width_select;
	logic        data_oe, port_wait, cal_pointer_advance, word_valid, test_restore, last_r;
	logic [15:0] data_in, data_out, read_word, word_data, last_w, q;
	int          num_errors = 0, n_checks = 0, cyc = 0, n_got = 0, n_cal = 0;
	apwp_host u_host (
		.clk           (clk),
		.data_out      (data_out),
		.chip_select_n (chip_select_n),
		.write_n       (write_n),
		.read_n        (read_n),
		.width_select  (width_select),
		.data_in       (data_in)
	);
	apwp_port #(.DEPTH(DEPTH)) DUT (
		.clk                 (clk),
		.reset_n             (reset_n),
		.chip_select_n       (chip_select_n),
		.write_n             (write_n),
		.read_n              (read_n),
		.width_select        (width_select),
		.data_in             (data_in),
		.data_out            (data_out),
		.data_oe             (data_oe),
		.port_wait           (port_wait),
		.read_word           (read_word),
		.cal_pointer_advance (cal_pointer_advance),
		.word_valid          (word_valid),
		.word_ready          (word_ready),
		.word_data           (word_data),
		.test_restore        (test_restore)
	);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (word_valid === 1'b1 && word_ready) begin
			last_w = word_data;
			last_r = test_restore;
			n_got++;
		end
		if (cal_pointer_advance === 1'b1) n_cal++;
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wt(input logic [15:0] e, input logic r, input int k);
		repeat (3) @(posedge clk);
		chk(last_w, e);
		chk({15'h0000, last_r}, {15'h0000, r});
		chk(16'(n_got), 16'(k));
	endtask
	task automatic t_word();
		u_host.wr(1'b1, 16'h8001);
		wt(16'h8001, 1'b0, 1);
		u_host.wr(1'b1, `APWP_RESTORE_WORD);
		wt(16'h0002, 1'b1, 2);
		$display("word test done");
	endtask
	task automatic t_byte();
		u_host.wr(1'b0, 16'hbe1f);
		wt(16'hbe1f, 1'b0, 3);
		u_host.strobe(16'h015a);
		wt(16'h5a1f, 1'b0, 4);
		$display("byte test done");
	endtask
	task automatic t_read();
		u_host.rd(1'b1, 1'b0, q);
		chk(q, 16'ha5c3);
		u_host.rd(1'b0, 1'b0, q);
		chk(q, 16'h00c3);
		u_host.rd(1'b0, 1'b1, q);
		chk(q, 16'h00a5);
		chk(16'(n_cal), 16'h0001);
		$display("read test done");
	endtask
	task automatic t_fill();
		word_ready <= 1'b0;
		repeat (DEPTH + 2) u_host.wr(1'b1, 16'h0100);
		chk({15'h0000, port_wait}, 16'h0001);
		word_ready <= 1'b1;
		repeat (20) @(posedge clk);
		chk(16'(n_got), 16'(4 + DEPTH + 1));
		$display("fill test done");
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		word_ready = 1'b1;
		read_word = 16'ha5c3;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_word();
		t_byte();
		t_read();
		t_fill();
		finish_test();
	end
endmodule
